// [rtl/gdf_pkg.sv]
// Constants and types shared by the gate driver fault controller
package gdf_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GATE_CMD = 8'h04;
	localparam logic [7:0] OFS_RESET_REQ = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// ==========================================================
	// Field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_INVERTING_BIT = 1;
	localparam int CTRL_GLOBAL_BIT = 2;
	localparam int CTRL_W = 3;
	localparam int STATUS_STICKY_LSB = 0;
	localparam int STATUS_LIVE_LSB = 8;
	localparam int STATUS_BUSY_LSB = 16;

	// ==========================================================
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int RESET_PULSE_NS = 3000;
	// Least time, rounded up to whole cycles
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Largest number of drivers sharing one fault line
	localparam int MAX_DRIVERS = 6;

	// ==========================================================
	// Per-driver reset sequencer states
	typedef enum logic [2:0] {
		RST_IDLE = 3'b001,
		RST_SAFE = 3'b010,
		RST_PULSE = 3'b100
	} gdf_rst_e;

endpackage

// [rtl/gdf_sync.sv]
// Two flip-flop synchroniser for pin inputs
module gdf_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_reg <= INIT;
			q <= INIT;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule // gdf_sync

// [rtl/gdf_ctrl.sv]
// Host controller driving isolated gate drivers: gate inputs, resets, fault polling
//
// Behaviour
// - Non-inverting: hold inverting input low; inverting: hold non-inverting high, or release it to the shared fault bus in global mode.
// - Host polls each fault line and resets each driver on its own.
// - Inverting use with shared fault bus stops all drivers, up to six.
// - Host commands gate off before it drives reset low.
//
// The register offsets and the Wishbone interface to the registers were decided locally.
module gdf_ctrl #(
	parameter int NUM_DRV = gdf_pkg::MAX_DRIVERS,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Driver gate inputs
	output logic [NUM_DRV-1:0] noninverting_gate_input,
	output logic [NUM_DRV-1:0] noninverting_gate_input_oe,
	output logic [NUM_DRV-1:0] inverting_gate_input,
	// Driver reset, active low
	output logic [NUM_DRV-1:0] driver_reset_n,
	// Driver fault lines, active low
	input wire logic [NUM_DRV-1:0] fault_n
);

	// ==========================================================
	// Elaboration checks
	if (NUM_DRV < 1 || NUM_DRV > gdf_pkg::MAX_DRIVERS) begin : g_chk_drv
		$error("NUM_DRV must be 1 to 6");
	end
	if (ADDR_W < 5) begin : g_chk_adr
		$error("ADDR_W too small for register map");
	end

	localparam int CNT_W = $clog2(gdf_pkg::RESET_PULSE_CYC + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(gdf_pkg::RESET_PULSE_CYC - 1);

	// ==========================================================
	// Fault line synchronisation
	logic [NUM_DRV-1:0] fault_n_sync;
	logic [NUM_DRV-1:0] fault_live;
	logic any_fault;

	gdf_sync #(
		.W(NUM_DRV),
		.INIT({NUM_DRV{1'b1}})
	) u_fault_sync (
		.clk(clk),
		.reset(reset),
		.d(fault_n),
		.q(fault_n_sync)
	);

	assign fault_live = ~fault_n_sync;
	assign any_fault = |fault_live;

	// ==========================================================
	// Register bus
	localparam int CTRL_W_L = gdf_pkg::CTRL_W;
	logic [CTRL_W_L-1:0] ctrl_reg;
	logic [NUM_DRV-1:0] cmd_reg;
	logic [NUM_DRV-1:0] sticky_reg;
	logic [NUM_DRV-1:0] rst_req;
	logic [NUM_DRV-1:0] sticky_clr;
	logic [NUM_DRV-1:0] busy;
	logic ack_reg;
	logic [31:0] dat_reg;
	logic bus_acc;
	logic bus_wr;
	logic [ADDR_W-1:0] adr;

	assign bus_acc = wb_cyc_i & wb_stb_i;
	assign bus_wr = bus_acc & wb_we_i & ack_reg & wb_sel_i[0];
	assign adr = wb_adr_i;
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// Ack one cycle after request, dropped the cycle after
	always_ff @(posedge clk) begin
		if (reset) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= bus_acc & ~ack_reg;
		end
	end

	// Read data, zero for unmapped offsets
	always_ff @(posedge clk) begin
		if (reset) begin
			dat_reg <= 32'h0000_0000;
		end else if (bus_acc & ~ack_reg) begin
			dat_reg <= 32'h0000_0000;
			if (adr == ADDR_W'(gdf_pkg::OFS_CTRL)) begin
				dat_reg[CTRL_W_L-1:0] <= ctrl_reg;
			end else if (adr == ADDR_W'(gdf_pkg::OFS_GATE_CMD)) begin
				dat_reg[NUM_DRV-1:0] <= cmd_reg;
			end else if (adr == ADDR_W'(gdf_pkg::OFS_RESET_REQ)) begin
				dat_reg[NUM_DRV-1:0] <= busy;
			end else if (adr == ADDR_W'(gdf_pkg::OFS_STATUS)) begin
				dat_reg[gdf_pkg::STATUS_STICKY_LSB +: NUM_DRV] <= sticky_reg;
				dat_reg[gdf_pkg::STATUS_LIVE_LSB +: NUM_DRV] <= fault_live;
				dat_reg[gdf_pkg::STATUS_BUSY_LSB +: NUM_DRV] <= busy;
			end
		end
	end

	// Control and gate command registers
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_reg <= gdf_pkg::CTRL_RESET;
			cmd_reg <= '0;
		end else if (bus_wr) begin
			if (adr == ADDR_W'(gdf_pkg::OFS_CTRL)) begin
				ctrl_reg <= wb_dat_i[CTRL_W_L-1:0];
			end else if (adr == ADDR_W'(gdf_pkg::OFS_GATE_CMD)) begin
				cmd_reg <= wb_dat_i[NUM_DRV-1:0];
			end
		end
	end

	assign rst_req = (bus_wr && adr == ADDR_W'(gdf_pkg::OFS_RESET_REQ)) ?
		wb_dat_i[NUM_DRV-1:0] : '0;
	assign sticky_clr = (bus_wr && adr == ADDR_W'(gdf_pkg::OFS_STATUS)) ?
		wb_dat_i[gdf_pkg::STATUS_STICKY_LSB +: NUM_DRV] : '0;

	// Sticky fault record, set wins over clear
	always_ff @(posedge clk) begin
		if (reset) begin
			sticky_reg <= '0;
		end else begin
			sticky_reg <= (sticky_reg & ~sticky_clr) | fault_live;
		end
	end

	logic enable;
	logic inv_mode;
	logic glob_mode;
	logic glob_trip;

	assign enable = ctrl_reg[gdf_pkg::CTRL_ENABLE_BIT];
	assign inv_mode = ctrl_reg[gdf_pkg::CTRL_INVERTING_BIT];
	assign glob_mode = ctrl_reg[gdf_pkg::CTRL_GLOBAL_BIT];
	assign glob_trip = glob_mode & any_fault;

	// ==========================================================
	// Per-driver gate control and reset sequencing
	logic [NUM_DRV-1:0] on_reg;

	for (genvar i = 0; i < NUM_DRV; i++) begin : g_drv
		gdf_pkg::gdf_rst_e st_reg;
		logic [CNT_W-1:0] cnt_reg;
		logic lock_reg;
		logic on_next;
		logic pulse_end;
		logic [CNT_W:0] low_cnt;

		assign busy[i] = (st_reg != gdf_pkg::RST_IDLE);
		assign pulse_end = (st_reg == gdf_pkg::RST_PULSE) && (cnt_reg == CNT_LAST);
		// Gate forced off on fault, during reset, and on a global trip
		assign on_next = enable & cmd_reg[i] & ~lock_reg & ~fault_live[i] & ~busy[i] &
			~glob_trip;

		// Fault lock until reset completes, set wins
		always_ff @(posedge clk) begin
			if (reset) begin
				lock_reg <= 1'b0;
			end else if (fault_live[i]) begin
				lock_reg <= 1'b1;
			end else if (pulse_end) begin
				lock_reg <= 1'b0;
			end
		end

		// Gate pins per input configuration
		always_ff @(posedge clk) begin
			if (reset) begin
				on_reg[i] <= 1'b0;
				noninverting_gate_input[i] <= 1'b0;
				inverting_gate_input[i] <= 1'b0;
				noninverting_gate_input_oe[i] <= 1'b1;
			end else begin
				on_reg[i] <= on_next;
				noninverting_gate_input[i] <= inv_mode | on_next;
				inverting_gate_input[i] <= inv_mode & ~on_next;
				// Shared fault bus drives this input in global inverting mode
				noninverting_gate_input_oe[i] <= ~(glob_mode & inv_mode);
			end
		end

		// Reset sequencer: gate off first, then timed low pulse
		always_ff @(posedge clk) begin
			if (reset) begin
				st_reg <= gdf_pkg::RST_IDLE;
				cnt_reg <= '0;
				driver_reset_n[i] <= 1'b1;
			end else begin
				case (st_reg)
					gdf_pkg::RST_IDLE: begin
						if (rst_req[i]) begin
							st_reg <= gdf_pkg::RST_SAFE;
						end
					end
					gdf_pkg::RST_SAFE: begin
						if (!on_reg[i]) begin
							st_reg <= gdf_pkg::RST_PULSE;
							cnt_reg <= '0;
							driver_reset_n[i] <= 1'b0;
						end
					end
					gdf_pkg::RST_PULSE: begin
						if (pulse_end) begin
							st_reg <= gdf_pkg::RST_IDLE;
							driver_reset_n[i] <= 1'b1;
						end else begin
							cnt_reg <= cnt_reg + 1'b1;
						end
					end
					default: begin
						st_reg <= gdf_pkg::RST_IDLE;
						driver_reset_n[i] <= 1'b1;
					end
				endcase
			end
		end

		// Helper: length of each reset low pulse
		always_ff @(posedge clk) begin
			if (reset) begin
				low_cnt <= '0;
			end else if (!driver_reset_n[i]) begin
				low_cnt <= low_cnt + 1'b1;
			end else begin
				low_cnt <= '0;
			end
		end

		property p_reset_gate_off;
			@(posedge clk) disable iff (reset)
			$fell(driver_reset_n[i]) |-> !$past(on_reg[i]) && !on_reg[i];
		endproperty
		a_reset_gate_off: assert property (p_reset_gate_off)
			else $error("reset driven low while gate commanded on");

		property p_reset_width;
			@(posedge clk) disable iff (reset)
			$rose(driver_reset_n[i]) |-> low_cnt == (CNT_W + 1)'(gdf_pkg::RESET_PULSE_CYC);
		endproperty
		a_reset_width: assert property (p_reset_width)
			else $error("driver reset pulse has wrong width");

		property p_fault_blocks;
			@(posedge clk) disable iff (reset)
			fault_live[i] |=> !on_reg[i] ##1 (!on_reg[i] || pulse_end || $past(pulse_end));
		endproperty
		a_fault_blocks: assert property (p_fault_blocks)
			else $error("gate left on after driver fault");

		property p_mode_pins;
			@(posedge clk) disable iff (reset)
			!$past(reset) |->
				($past(inv_mode) ? noninverting_gate_input[i] == 1'b1 &&
					inverting_gate_input[i] == !on_reg[i] :
				inverting_gate_input[i] == 1'b0 &&
					noninverting_gate_input[i] == on_reg[i]);
		endproperty
		a_mode_pins: assert property (p_mode_pins)
			else $error("gate pins do not match input configuration");
	end

	property p_global_trip;
		@(posedge clk) disable iff (reset)
		(glob_mode && any_fault) |=> on_reg == '0;
	endproperty
	a_global_trip: assert property (p_global_trip)
		else $error("global trip left a driver on");

endmodule // gdf_ctrl

// [bench/gdf_drv_model.sv]
// Behavioural model of the isolated gate drivers beyond the controller
module gdf_drv_model #(
	parameter int N = 6
) (
	// Clock
	input wire logic clk,
	// Pins from the controller
	input wire logic [N-1:0] noninverting_gate_input,
	input wire logic [N-1:0] noninverting_gate_input_oe,
	input wire logic [N-1:0] inverting_gate_input,
	input wire logic [N-1:0] driver_reset_n,
	// Sensed desaturation, supply lockout and below-limit flags
	input wire logic [N-1:0] desat,
	input wire logic supply_lockout,
	input wire logic below_limit,
	// Fault lines, signal channel state and output stage
	output logic [N-1:0] fault_n,
	output logic [N-1:0] chan_on,
	output logic [N-1:0] gate_drive_output,
	output logic [N-1:0] strong_dn
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [N-1:0] fault_reg = '0;
	logic [N-1:0] chan_prev = '0;
	logic [N-1:0] out_flag = '0;
	logic [N-1:0] pull_up;
	logic [N-1:0] pin_p;
	logic bus_level;
	// Open collector with pull-up: released reads high
	assign fault_n = ~fault_reg;
	assign bus_level = &fault_n;
	always_comb begin
		for (int i = 0; i < N; i++) begin
			pin_p[i] = noninverting_gate_input_oe[i] ? noninverting_gate_input[i] : bus_level;
		end
	end
	// Reset pin does not steer the channel
	assign chan_on = pin_p & ~inverting_gate_input & ~fault_reg;
	always @(posedge clk) begin
		for (int i = 0; i < N; i++) begin
			if (!driver_reset_n[i]) begin
				fault_reg[i] <= 1'b0;
			end else if (desat[i] && chan_on[i] && chan_prev[i]) begin
				fault_reg[i] <= 1'b1;
			end
		end
	end
	// Blanking: desaturation counts only once the channel was on a cycle
	always @(posedge clk) begin
		chan_prev <= chan_on;
	end
	// Output-side flag: set by desaturation while on, cleared when channel off
	always @(posedge clk) begin
		out_flag <= chan_on & (out_flag | (desat & chan_prev));
	end
	// Output stage; weak discharge only while flag set and gate above limit
	assign pull_up = chan_on & ~out_flag & ~{N{supply_lockout}};
	assign strong_dn = ~pull_up & (~out_flag | {N{below_limit | supply_lockout}});
	assign gate_drive_output = pull_up;
endmodule // gdf_drv_model

// [bench/test_gate_driver_fault_latch.sv]
// Self-checking bench for the gate driver fault controller
`define GDF_CHK(g, e) chk(32'(g), 32'(e))
module test_gate_driver_fault_latch;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int N = 6;
	logic clk, reset, cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [N-1:0] nig, nig_oe, ig, drst_n, fault_n, desat, chan_on, gdo, sdn;
	logic lockout, below;
	int fail_count, n_checks;

	gdf_ctrl #(.NUM_DRV(N), .ADDR_W(8)) gdf_ctrl_i (.clk(clk), .reset(reset),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .noninverting_gate_input(nig),
		.noninverting_gate_input_oe(nig_oe), .inverting_gate_input(ig),
		.driver_reset_n(drst_n), .fault_n(fault_n));
	gdf_drv_model #(.N(N)) gdf_drv_model_i (.clk(clk), .noninverting_gate_input(nig),
		.noninverting_gate_input_oe(nig_oe), .inverting_gate_input(ig),
		.driver_reset_n(drst_n), .desat(desat), .supply_lockout(lockout), .below_limit(below),
		.fault_n(fault_n), .chan_on(chan_on), .gate_drive_output(gdo), .strong_dn(sdn));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ==========================================================
	// Shared tasks
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	function automatic void chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endfunction

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) begin
			fail_count++;
			close_out();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
		repeat (3) @(posedge clk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h0000_0000, r);
		`GDF_CHK(r, e);
	endtask

	task automatic pulse_desat(input logic [N-1:0] m);
		@(posedge clk);
		desat <= m;
		@(posedge clk);
		desat <= '0;
		repeat (5) @(posedge clk);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset_state();
		`GDF_CHK(drst_n, 8'h3F);
		`GDF_CHK(fault_n, 8'h3F);
		`GDF_CHK(chan_on, 8'h00);
		rd_chk(gdf_pkg::OFS_STATUS, 32'h0000_0000);
		wr(8'h10, 32'hFFFF_FFFF);
		rd_chk(8'h10, 32'h0000_0000);
		rd_chk(gdf_pkg::OFS_CTRL, 32'h0000_0000);
	endtask

	task automatic t_modes();
		wr(gdf_pkg::OFS_CTRL, 32'h0000_0001);
		wr(gdf_pkg::OFS_GATE_CMD, 32'h0000_003A);
		`GDF_CHK({nig, ig}, 12'hE80);
		`GDF_CHK(chan_on, 8'h3A);
		`GDF_CHK({gdo, sdn}, 12'hE85);
		lockout <= 1'b1;
		@(posedge clk);
		`GDF_CHK({gdo, sdn}, 12'h03F);
		lockout <= 1'b0;
		wr(gdf_pkg::OFS_CTRL, 32'h0000_0003);
		`GDF_CHK({nig_oe, nig, ig}, 24'h03_FFC5);
		`GDF_CHK(chan_on, 8'h3A);
	endtask

	task automatic t_fault_reset();
		int n;
		logic [31:0] r;
		wr(gdf_pkg::OFS_CTRL, 32'h0000_0001);
		wr(gdf_pkg::OFS_GATE_CMD, 32'h0000_0003);
		pulse_desat(6'h01);
		`GDF_CHK(fault_n, 8'h3E);
		`GDF_CHK({nig, drst_n}, 12'h0BF);
		rd_chk(gdf_pkg::OFS_STATUS, 32'h0000_0101);
		wb(1'b1, gdf_pkg::OFS_RESET_REQ, 32'h0000_0001, r);
		n = 0;
		while (drst_n[0] !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n == 20) begin
			fail_count++;
			close_out();
		end
		`GDF_CHK(nig[0], 1'b0);
		n = 0;
		while (drst_n[0] === 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n == 200) begin
			fail_count++;
			close_out();
		end
		`GDF_CHK(n, gdf_pkg::RESET_PULSE_CYC);
		`GDF_CHK(fault_n, 8'h3F);
		repeat (3) @(posedge clk);
		`GDF_CHK(nig, 8'h03);
		rd_chk(gdf_pkg::OFS_STATUS, 32'h0000_0001);
		wr(gdf_pkg::OFS_STATUS, 32'h0000_0001);
		rd_chk(gdf_pkg::OFS_STATUS, 32'h0000_0000);
	endtask

	task automatic t_global();
		wr(gdf_pkg::OFS_CTRL, 32'h0000_0007);
		wr(gdf_pkg::OFS_GATE_CMD, 32'h0000_003F);
		`GDF_CHK({nig_oe, ig, chan_on}, 24'h00_003F);
		pulse_desat(6'h04);
		`GDF_CHK({ig, chan_on}, 12'hFC0);
		rd_chk(gdf_pkg::OFS_STATUS, 32'h0000_0404);
	endtask

	initial begin
		fail_count = 0;
		n_checks = 0;
		reset = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hF;
		wdat = 32'h0000_0000;
		desat = '0;
		lockout = 1'b0;
		below = 1'b0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		t_reset_state();
		t_modes();
		t_fault_reset();
		t_global();
		close_out();
	end
endmodule // test_gate_driver_fault_latch
